// ### cgr_pkg.sv
package cgr_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  // status index; byte address is four times the index
  localparam logic [31:0] CGR_STATUS_IDX = 32'h0000_002B;
  localparam logic [31:0] CGR_STATUS_ADDR = 32'h0000_00AC;
  localparam logic [31:0] CGR_IRQ_ADDR = 32'h0000_0030;
  localparam logic [31:0] CGR_MASK_ADDR = 32'h0000_0034;
  localparam logic [31:0] CGR_CTRL_ADDR = 32'h0000_0038;
  localparam logic [31:0] CGR_MON_ADDR = 32'h0000_003C;
  localparam logic [1:0] CGR_WORD_MASK = 2'h3;
  // ------------------------------------------------------------
  // status fields
  // ------------------------------------------------------------
  localparam int CGR_WDG_BIT = 0;
  localparam int CGR_SAFE_BIT = 1;
  localparam int CGR_IEN_BIT = 2;
  localparam int CGR_LVR_BIT = 4;
  localparam logic [7:0] CGR_STATUS_WMASK = 8'h15;
  // ------------------------------------------------------------
  // irq status bits
  // ------------------------------------------------------------
  localparam int CGR_EV_SAFE = 0;
  localparam int CGR_EV_FILT = 1;
  localparam int CGR_EV_BACK = 2;
  localparam int CGR_NEV = 3;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CGR_SAFE_PERIOD = 16;
  localparam int CGR_MIN_HALF = 2;
  localparam int CGR_GOOD_EDGES = 4;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CGR_MAIN = 3'b001,
    CGR_FILT = 3'b010,
    CGR_SAFE = 3'b100
  } cgr_sel_t;
endpackage

// ### cgr_clock_guard.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// - guard enabled by a static strap, not by any register
// - filter drops main clock pulses shorter than a minimum width
// - too-fast oscillator suppressed; resumes automatically when normal again
// - no main edge for one safe period selects safe oscillator
// - main clock recovery switches core back to main automatically
// - safe selection sets flag bit 1; guard_irq needs bit 2 and core unmask
// - bit 2 is read/write enable, ignored when guard disabled
// - flag clears on status read after recovery; zero when disabled
// - wait does not stop the guard; irq wakes wait, not halt
// - in halt status frozen and guard stopped
// - low-voltage flag set by supply reset, cleared by writing zero
// - watchdog flag set by watchdog reset, cleared by zero, pin reset or supply reset
// - pin and watchdog resets clear the low-voltage flag
// - flags encode last reset: 00 pin, 01 watchdog, 1x supply
// - bits 7:5 and 3 read as zero
// - reset value zero except the two reset-cause flags
module cgr_clock_guard #(
  parameter int SAFE_PERIOD = cgr_pkg::CGR_SAFE_PERIOD,
  parameter int MIN_HALF = cgr_pkg::CGR_MIN_HALF,
  parameter int GOOD_EDGES = cgr_pkg::CGR_GOOD_EDGES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic guard_strap,
  input wire logic lvr_cause,
  input wire logic wdg_cause,
  input wire logic main_osc,
  input wire logic safe_osc,
  input wire logic core_irq_mask,
  input wire logic halt_mode,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic core_clk,
  output logic safe_sel,
  output logic guard_irq,
  output logic irq
);
  import cgr_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic started;
    logic en;
    logic wdg;
    logic lvr;
    logic ien;
    logic safe_flag;
    cgr_sel_t sel;
    logic osc_prev;
    logic [7:0] hi_cnt;
    logic [7:0] gap_cnt;
    logic [7:0] good_cnt;
    logic clk_out;
    logic [CGR_NEV-1:0] ev;
    logic [CGR_NEV-1:0] mask;
    logic ap_valid;
    logic ap_write;
    logic [31:0] ap_addr;
    logic [31:0] rdata;
  } cgr_state_t;

  cgr_state_t s_q, s_d;
  logic main_edge, short_pulse, phase_ok;
  logic [7:0] status_v;

  always_comb begin
    main_edge = main_osc & ~s_q.osc_prev;
    short_pulse = (main_osc != s_q.osc_prev) &&
      (s_q.hi_cnt < 8'(MIN_HALF));
    phase_ok = (main_osc != s_q.osc_prev) && !short_pulse;
    status_v = 8'h00;
    status_v[CGR_LVR_BIT] = s_q.lvr;
    status_v[CGR_IEN_BIT] = s_q.ien;
    status_v[CGR_SAFE_BIT] = s_q.safe_flag & s_q.en;
    status_v[CGR_WDG_BIT] = s_q.wdg;
  end

  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h0000_0000;
    // ----------------------------------------------------------
    // strap and reset cause capture after release
    // ----------------------------------------------------------
    if (!s_q.started) begin
      s_d.started = 1'b1;
      s_d.en = guard_strap;
      s_d.lvr = lvr_cause;
      s_d.wdg = wdg_cause & ~lvr_cause;
    end
    // ----------------------------------------------------------
    // clock filter and safe switch, stopped in halt
    // ----------------------------------------------------------
    if (s_q.en && !halt_mode) begin
      s_d.osc_prev = main_osc;
      if (main_osc != s_q.osc_prev) begin
        s_d.hi_cnt = 8'h00;
      end else if (s_q.hi_cnt != 8'hFF) begin
        s_d.hi_cnt = s_q.hi_cnt + 8'h01;
      end
      if (main_edge && !short_pulse) begin
        s_d.gap_cnt = 8'h00;
      end else if (s_q.gap_cnt != 8'hFF) begin
        s_d.gap_cnt = s_q.gap_cnt + 8'h01;
      end
      unique case (s_q.sel)
        CGR_MAIN: begin
          if (phase_ok) begin
            s_d.clk_out = main_osc;
          end
          if (short_pulse) begin
            s_d.sel = CGR_FILT;
            s_d.ev[CGR_EV_FILT] = 1'b1;
            s_d.good_cnt = 8'h00;
          end else if (s_q.gap_cnt >= 8'(SAFE_PERIOD)) begin
            s_d.sel = CGR_SAFE;
            s_d.safe_flag = 1'b1;
            s_d.ev[CGR_EV_SAFE] = 1'b1;
            s_d.good_cnt = 8'h00;
          end
        end
        CGR_FILT: begin
          if (short_pulse) begin
            s_d.good_cnt = 8'h00;
          end else if (main_edge) begin
            s_d.good_cnt = s_q.good_cnt + 8'h01;
          end
          if (s_q.good_cnt >= 8'(GOOD_EDGES)) begin
            s_d.sel = CGR_MAIN;
          end else if (s_q.gap_cnt >= 8'(SAFE_PERIOD)) begin
            s_d.sel = CGR_SAFE;
            s_d.safe_flag = 1'b1;
            s_d.ev[CGR_EV_SAFE] = 1'b1;
          end
        end
        CGR_SAFE: begin
          s_d.clk_out = safe_osc;
          if (short_pulse) begin
            s_d.good_cnt = 8'h00;
          end else if (main_edge) begin
            s_d.good_cnt = s_q.good_cnt + 8'h01;
          end
          if (s_q.good_cnt >= 8'(GOOD_EDGES)) begin
            s_d.sel = CGR_MAIN;
            s_d.ev[CGR_EV_BACK] = 1'b1;
          end
        end
        default: s_d.sel = CGR_MAIN;
      endcase
    end else if (!s_q.en) begin
      // track the pin so enabling sees no false edge
      s_d.osc_prev = main_osc;
      s_d.clk_out = main_osc;
      s_d.sel = CGR_MAIN;
      s_d.safe_flag = 1'b0;
    end
    // ----------------------------------------------------------
    // bus data phase
    // ----------------------------------------------------------
    if (s_q.ap_valid && !halt_mode) begin
      if (s_q.ap_write) begin
        unique case (s_q.ap_addr & ~{30'h0, CGR_WORD_MASK})
          CGR_STATUS_ADDR & ~{30'h0, CGR_WORD_MASK}: begin
            // lvr and wdg clear only by zero, set only by hardware; ien takes the written bit
            if (!hwdata[CGR_LVR_BIT]) begin
              s_d.lvr = 1'b0;
            end
            if (!hwdata[CGR_WDG_BIT]) begin
              s_d.wdg = 1'b0;
            end
            s_d.ien = hwdata[CGR_IEN_BIT];
          end
          CGR_MASK_ADDR: s_d.mask = hwdata[CGR_NEV-1:0];
          default: ;
        endcase
      end
    end
    // ----------------------------------------------------------
    // bus address phase and read data
    // ----------------------------------------------------------
    s_d.ap_valid = hsel && hready && htrans[1];
    s_d.ap_write = hwrite;
    s_d.ap_addr = haddr;
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr & ~{30'h0, CGR_WORD_MASK})
        CGR_STATUS_ADDR & ~{30'h0, CGR_WORD_MASK}: begin
          s_d.rdata = {24'h0, status_v};
          // read clears flag only once main clock is back
          if (s_q.sel == CGR_MAIN && !halt_mode &&
              !(s_d.sel == CGR_SAFE)) begin
            s_d.safe_flag = 1'b0;
          end
        end
        CGR_IRQ_ADDR: begin
          s_d.rdata = {29'h0, s_q.ev};
          s_d.ev = s_d.ev & ~s_q.ev;
        end
        CGR_MASK_ADDR: s_d.rdata = {29'h0, s_q.mask};
        CGR_CTRL_ADDR: s_d.rdata = {31'h0, s_q.en};
        CGR_MON_ADDR: s_d.rdata = {29'h0, s_q.sel};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{started: 1'b0, en: 1'b0, wdg: 1'b0, lvr: 1'b0,
        ien: 1'b0, safe_flag: 1'b0, sel: CGR_MAIN, osc_prev: 1'b0,
        hi_cnt: 8'hFF, gap_cnt: 8'h00, good_cnt: 8'h00,
        clk_out: 1'b0, ev: '0, mask: '0, ap_valid: 1'b0,
        ap_write: 1'b0, ap_addr: 32'h0000_0000,
        rdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign core_clk = s_q.clk_out;
  assign safe_sel = (s_q.sel == CGR_SAFE);
  // level to the core, gated here with core_irq_mask; wakes wait
  assign guard_irq = s_q.en & s_q.safe_flag & s_q.ien & 
    ~core_irq_mask;
  assign irq = |(s_q.ev & s_q.mask);
endmodule
`default_nettype wire

// ### cgr_osc_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// main oscillator: 0 normal, 1 stopped, 2 harmonic spikes
// ------------------------------------------------------------
module cgr_osc_model (
  input wire logic hclk,
  input wire logic [1:0] mode,
  output logic main_osc
);
  logic [1:0] cnt_q = 2'h0;
  initial main_osc = 1'b0;
  always @(posedge hclk) begin
    cnt_q <= cnt_q + 2'h1;
    if (mode == 2'h2 || (mode == 2'h0 && cnt_q == 2'h3)) begin
      main_osc <= ~main_osc;
    end
  end
endmodule
`default_nettype wire

// ### cgr_clock_guard_sva.sv
`timescale 1ns/100ps
`default_nettype none
module cgr_clock_guard_sva
  import cgr_pkg::*;
#(
  parameter int SAFE_PERIOD = CGR_SAFE_PERIOD
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic guard_strap,
  input wire logic main_osc,
  input wire logic core_irq_mask,
  input wire logic halt_mode,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic safe_sel,
  input wire logic guard_irq
);
  logic [7:0] dead_q;
  logic main_q;
  logic acc_q;
  wire logic acc = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dead_q <= 8'h00;
      main_q <= 1'b0;
      acc_q <= 1'b0;
    end else begin
      main_q <= main_osc;
      acc_q <= acc;
      if (main_osc != main_q || halt_mode) dead_q <= 8'h00;
      else if (dead_q != 8'hFF) dead_q <= dead_q + 8'h01;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd; acc && !hwrite && haddr[31:2] == CGR_STATUS_ADDR[31:2];
  endsequence
  property p_ready; hreadyout && !hresp; endproperty
  a_ready: assert property (p_ready) else $error("not zero-wait okay");
  property p_idle; !(acc && !hwrite) |=> hrdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside phase");
  property p_rsvd; s_rd |=> hrdata[31:5] == 27'h0 && !hrdata[3]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_mask; core_irq_mask |-> !guard_irq; endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  property p_strap; !guard_strap |-> !safe_sel && !guard_irq; endproperty
  a_strap: assert property (p_strap) else $error("guard off but active");
  property p_halt; halt_mode ##1 halt_mode |-> $stable(safe_sel); endproperty
  a_halt: assert property (p_halt) else $error("select moved in halt");
  property p_dead;
    dead_q == SAFE_PERIOD + 6 && guard_strap |-> safe_sel;
  endproperty
  a_dead: assert property (p_dead) else $error("no safe switch");
  property p_hold;
    guard_irq && !acc && !acc_q |=> guard_irq || core_irq_mask;
  endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  c_safe: cover property ($rose(safe_sel));
  c_back: cover property ($fell(safe_sel));
  c_irq: cover property (guard_irq);
endmodule
bind cgr_clock_guard cgr_clock_guard_sva #(.SAFE_PERIOD(SAFE_PERIOD)) u_sva (
  .hclk, .hresetn, .guard_strap, .main_osc, .core_irq_mask, .halt_mode,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .safe_sel, .guard_irq
);
`default_nettype wire

// ### tb_cgr_clock_guard.sv
`timescale 1ns/100ps
`default_nettype none
module tb_cgr_clock_guard;
  import cgr_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, guard_strap = 1'b1, safe_osc = 1'b0;
  logic lvr_cause = 1'b0, wdg_cause = 1'b0, halt_mode = 1'b0;
  logic core_irq_mask = 1'b1, hsel = 1'b0, hwrite = 1'b0, rd_dp = 1'b0;
  logic [1:0] htrans = 2'h0, osc_mode = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic main_osc, hreadyout, hresp, core_clk, safe_sel, guard_irq, irq;
  logic [31:0] exp_q[$];
  int bad_count = 0;
  int comparisons = 0;
  always #2 hclk = ~hclk;
  always #14 safe_osc = ~safe_osc;
  cgr_osc_model u_cgr_osc_model (.hclk, .mode(osc_mode), .main_osc);
  cgr_clock_guard u_cgr_clock_guard (
    .hclk, .hresetn, .guard_strap, .lvr_cause, .wdg_cause, .main_osc,
    .safe_osc, .core_irq_mask, .halt_mode, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .core_clk, .safe_sel, .guard_irq, .irq
  );
  task automatic check(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d, e);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    if (!w) exp_q.push_back(e);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rst(input logic l, w, s);
    hresetn <= 1'b0;
    lvr_cause <= l;
    wdg_cause <= w;
    guard_strap <= s;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask
  task automatic run(input int n, input logic [1:0] m);
    osc_mode <= m;
    repeat (n) @(posedge hclk);
  endtask
  task automatic complete_run;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    if (rd_dp) check("hrdata", hrdata, exp_q.pop_front());
    if (rd_dp) check("hresp", {hreadyout, hresp}, 32'h2);
    rd_dp = hsel && htrans[1] && !hwrite && hreadyout;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    complete_run;
  end
  initial begin
    void'($urandom(69));
    rst(1'b1, 1'b0, 1'b1);
    xfer(1'b0, CGR_STATUS_ADDR, 0, 32'h10);
    xfer(1'b1, CGR_STATUS_ADDR, ($urandom & 32'hFFFF_FFEA) | 32'h4, 0);
    xfer(1'b0, CGR_STATUS_ADDR, 0, 32'h04);
    rst(1'b0, 1'b1, 1'b1);
    xfer(1'b0, CGR_STATUS_ADDR, 0, 32'h01);
    rst(1'b1, 1'b1, 1'b1);
    xfer(1'b0, CGR_STATUS_ADDR, 0, 32'h10);
    xfer(1'b1, CGR_STATUS_ADDR, 0, 0);
    xfer(1'b0, CGR_STATUS_ADDR, 0, 32'h00);
    rst(1'b0, 1'b0, 1'b1);
    xfer(1'b0, CGR_STATUS_ADDR, 0, 32'h00);
    xfer(1'b1, CGR_MASK_ADDR, 32'h1, 0);
    xfer(1'b1, CGR_STATUS_ADDR, 32'h4, 0);
    core_irq_mask <= 1'b0;
    run(40, 2'h1);
    check("safe_sel", safe_sel, 1);
    check("guard_irq", guard_irq, 1);
    check("irq", irq, 1);
    xfer(1'b0, CGR_STATUS_ADDR, 0, 32'h06);
    core_irq_mask <= 1'b1;
    run(2, 2'h1);
    check("guard_irq", guard_irq, 0);
    core_irq_mask <= 1'b0;
    run(100, 2'h0);
    check("safe_sel", safe_sel, 0);
    check("guard_irq", guard_irq, 1);
    xfer(1'b0, CGR_STATUS_ADDR, 0, 32'h06);
    xfer(1'b0, CGR_STATUS_ADDR, 0, 32'h04);
    xfer(1'b0, CGR_IRQ_ADDR, 0, 32'h05);
    run(2, 2'h0);
    check("irq", irq, 0);
    xfer(1'b1, 32'h40, $urandom, 0);
    xfer(1'b0, 32'h40, 0, 0);
    run(60, 2'h2);
    check("safe_sel", safe_sel, 1);
    run(100, 2'h0);
    check("safe_sel", safe_sel, 0);
    halt_mode <= 1'b1;
    run(60, 2'h1);
    check("safe_sel", safe_sel, 0);
    halt_mode <= 1'b0;
    rst(1'b0, 1'b0, 1'b0);
    xfer(1'b1, CGR_STATUS_ADDR, 32'h4, 0);
    run(60, 2'h1);
    check("safe_sel", safe_sel, 0);
    check("guard_irq", guard_irq, 0);
    check("core_clk", core_clk, main_osc);
    xfer(1'b0, CGR_STATUS_ADDR, 0, 32'h04);
    complete_run;
  end
endmodule
`default_nettype wire
